// ==== core/t8w_top.sv ====
// Timer core with mode decode, two compare channels, pin drive and interrupt flags.
// Assumes a plain register port on the same clock and a one-cycle timer tick enable.
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
// Notes on behaviour
// - Logic runs on system clock; tick only enables.
// - Channel A drives pin when mode nonzero.
// - Non-PWM A: off, toggle, clear, set on match.
// - Fast A: toggle needs high mode bit, else pin released; clear/set PWM.
// - Fast PWM, compare equals TOP: act at BOTTOM.
// - Phase A: clear up, set down, or inverse.
// - Phase PWM, compare equals TOP: act at TOP.
// - Channel B drives pin when mode nonzero.
// - Non-PWM B: off, toggle, clear, set on match.
// - Fast B: toggle reserved; clear/set match, BOTTOM.
// - Phase B: toggle reserved; up/down match levels.
// - Control A bits 3:2 read zero.
// - Three mode bits select counting and TOP.
// - Compare update and overflow point per mode.
module t8w_top
    import t8w_pkg::*;
#(
    parameter int COUNT_W = CNT_W
)
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Timer clock enable
    input wire logic timer_tick_enable_in,
    // Waveform pins
    output logic chan_a_wave_out,
    output logic chan_a_wave_oe_out,
    output logic chan_b_wave_out,
    output logic chan_b_wave_oe_out,
    // Interrupt
    output logic irq_out
);
    generate
        if (COUNT_W != 8)
        begin : g_width_check
            $error("t8w_top serves an 8-bit counter only");
        end
    endgenerate

    logic [7:0] ctrl_a_q;
    logic [7:0] ctrl_a_d;
    logic wave_mode_high_q;
    logic wave_mode_high_d;
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic up_q;
    logic up_d;
    logic block_q;
    logic block_d;
    logic [ST_W-1:0] status_q;
    logic [ST_W-1:0] status_d;
    logic [ST_W-1:0] mask_q;
    logic [ST_W-1:0] mask_d;
    logic [1:0] pin_dir_q;
    logic [1:0] pin_dir_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic irq_q;
    logic irq_d;
    logic oe_a_q;
    logic oe_a_d;
    logic oe_b_q;
    logic oe_b_d;
    t8w_mode_t mode;
    logic [7:0] top;
    logic tick;
    logic ovf;
    logic wr_ctrl_a;
    logic [ST_W-1:0] events;
    logic [7:0] buf_a;
    logic [7:0] buf_b;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic match_a;
    logic match_b;
    logic conn_a;
    logic conn_b;

    // The tick is only an enable, so all state stays on one clock.
    assign tick = timer_tick_enable_in;
    assign mode = t8w_mode_t'({wave_mode_high_q, ctrl_a_q[CA_WAVE_LOW_LSB +: 2]});

    always_comb
    begin
        unique case (mode)
            T8W_CLR_MATCH, T8W_PHASE_CMP, T8W_FAST_CMP: top = cmp_a;
            default: top = CNT_MAX;
        endcase
    end

    // Counter, direction and overflow event.
    always_comb
    begin
        count_d = count_q;
        up_d = up_q;
        ovf = 1'b0;
        block_d = tick ? 1'b0 : block_q;
        if (tick)
        begin
            unique case (mode)
                T8W_NORMAL:
                begin
                    count_d = 8'(count_q + 8'h01);
                    ovf = (count_q == CNT_MAX);
                end
                T8W_CLR_MATCH, T8W_FAST_FF, T8W_FAST_CMP:
                begin
                    count_d = (count_q == top) ? CNT_BOTTOM : 8'(count_q + 8'h01);
                    if (mode == T8W_FAST_CMP)
                        ovf = (count_q == top);
                    else
                        ovf = (count_q == CNT_MAX);
                end
                T8W_PHASE_FF, T8W_PHASE_CMP:
                begin
                    ovf = (count_q == CNT_BOTTOM);
                    if (up_q && count_q == top)
                    begin
                        up_d = 1'b0;
                        count_d = 8'(count_q - 8'h01);
                    end
                    else if (!up_q && count_q == CNT_BOTTOM)
                    begin
                        up_d = 1'b1;
                        count_d = 8'(count_q + 8'h01);
                    end
                    else
                        count_d = up_q ? 8'(count_q + 8'h01) : 8'(count_q - 8'h01);
                end
                T8W_RSV4, T8W_RSV6: count_d = count_q;
            endcase
        end
        if (mode != T8W_PHASE_FF && mode != T8W_PHASE_CMP)
            up_d = 1'b1;
        // A software write to the counter masks the match on the next tick.
        if (reg_wr_in && reg_addr_in == ADDR_COUNT)
        begin
            count_d = reg_wdata_in;
            block_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            count_q <= RST_REG;
            up_q <= 1'b1;
            block_q <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            up_q <= up_d;
            block_q <= block_d;
        end
    end

    assign wr_ctrl_a = reg_wr_in && reg_addr_in == ADDR_CTRL_A;

    t8w_chan #(
        .PWM_TOGGLE(1'b1)
    ) u_chan_a (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .tick_in(tick),
        .mode_in(mode),
        .wave_mode_high_in(wave_mode_high_q),
        .count_in(count_q),
        .top_in(top),
        .up_in(up_q),
        .block_in(block_q),
        .out_mode_in(ctrl_a_q[CA_MODE_A_LSB +: 2]),
        .wr_in(reg_wr_in && reg_addr_in == ADDR_CMP_A),
        .wdata_in(reg_wdata_in),
        .buf_out(buf_a),
        .compare_out(cmp_a),
        .match_out(match_a),
        .wave_out(chan_a_wave_out),
        .connected_out(conn_a)
    );

    t8w_chan #(
        .PWM_TOGGLE(1'b0)
    ) u_chan_b (
        .core_clk_in(core_clk_in),
        .sys_rst_in(sys_rst_in),
        .tick_in(tick),
        .mode_in(mode),
        .wave_mode_high_in(wave_mode_high_q),
        .count_in(count_q),
        .top_in(top),
        .up_in(up_q),
        .block_in(block_q),
        .out_mode_in(ctrl_a_q[CA_MODE_B_LSB +: 2]),
        .wr_in(reg_wr_in && reg_addr_in == ADDR_CMP_B),
        .wdata_in(reg_wdata_in),
        .buf_out(buf_b),
        .compare_out(cmp_b),
        .match_out(match_b),
        .wave_out(chan_b_wave_out),
        .connected_out(conn_b)
    );

    // Registers, flags, pin enables and read data.
    always_comb
    begin
        ctrl_a_d = ctrl_a_q;
        wave_mode_high_d = wave_mode_high_q;
        mask_d = mask_q;
        pin_dir_d = pin_dir_q;
        if (wr_ctrl_a)
            ctrl_a_d = {reg_wdata_in[7:4], 2'b00, reg_wdata_in[1:0]};
        if (reg_wr_in && reg_addr_in == ADDR_CTRL_X)
            wave_mode_high_d = reg_wdata_in[CX_WAVE_HIGH_BIT];
        if (reg_wr_in && reg_addr_in == ADDR_MASK)
            mask_d = reg_wdata_in[ST_W-1:0];
        if (reg_wr_in && reg_addr_in == ADDR_PIN_DIR)
            pin_dir_d = reg_wdata_in[1:0];
        events = '0;
        events[ST_OVF_BIT] = ovf;
        events[ST_MATCH_A_BIT] = match_a;
        events[ST_MATCH_B_BIT] = match_b;
        status_d = status_q;
        if (reg_wr_in && reg_addr_in == ADDR_STATUS)
            status_d = status_q & ~reg_wdata_in[ST_W-1:0];
        // A new event beats a clear arriving in the same cycle.
        status_d = status_d | events;
        irq_d = |(status_d & mask_d);
        oe_a_d = conn_a && pin_dir_q[0];
        oe_b_d = conn_b && pin_dir_q[1];
        rdata_d = 8'h00;
        if (reg_rd_in)
        begin
            unique case (reg_addr_in)
                ADDR_CTRL_A: rdata_d = {ctrl_a_q[7:4], 2'b00, ctrl_a_q[1:0]};
                ADDR_CTRL_X: rdata_d = 8'(wave_mode_high_q) << CX_WAVE_HIGH_BIT;
                ADDR_COUNT: rdata_d = count_q;
                ADDR_CMP_A: rdata_d = buf_a;
                ADDR_CMP_B: rdata_d = buf_b;
                ADDR_STATUS: rdata_d = {5'h00, status_q};
                ADDR_MASK: rdata_d = {5'h00, mask_q};
                ADDR_PIN_DIR: rdata_d = {6'h00, pin_dir_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            ctrl_a_q <= RST_REG;
            wave_mode_high_q <= 1'b0;
            mask_q <= '0;
            pin_dir_q <= 2'b00;
            status_q <= '0;
            irq_q <= 1'b0;
            oe_a_q <= 1'b0;
            oe_b_q <= 1'b0;
            rdata_q <= RST_REG;
        end
        else
        begin
            ctrl_a_q <= ctrl_a_d;
            wave_mode_high_q <= wave_mode_high_d;
            mask_q <= mask_d;
            pin_dir_q <= pin_dir_d;
            status_q <= status_d;
            irq_q <= irq_d;
            oe_a_q <= oe_a_d;
            oe_b_q <= oe_b_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_out = rdata_q;
    assign irq_out = irq_q;
    assign chan_a_wave_oe_out = oe_a_q;
    assign chan_b_wave_oe_out = oe_b_q;
endmodule // t8w_top

// ==== core/t8w_pkg.sv ====
// Constants, register map and mode codes for the 8-bit timer waveform block.
// Assumes one clock domain; every offset is a byte address on the plain register port.
package t8w_pkg;
    localparam int CNT_W = 8;
    localparam logic [7:0] ADDR_CTRL_A = 8'h24;
    localparam logic [7:0] ADDR_CTRL_X = 8'h25;
    localparam logic [7:0] ADDR_COUNT = 8'h26;
    localparam logic [7:0] ADDR_CMP_A = 8'h27;
    localparam logic [7:0] ADDR_CMP_B = 8'h28;
    localparam logic [7:0] ADDR_STATUS = 8'h29;
    localparam logic [7:0] ADDR_MASK = 8'h2a;
    localparam logic [7:0] ADDR_PIN_DIR = 8'h2b;
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;
    localparam int CA_MODE_A_LSB = 6;
    localparam int CA_MODE_B_LSB = 4;
    localparam int CA_WAVE_LOW_LSB = 0;
    localparam int CX_WAVE_HIGH_BIT = 3;
    localparam int ST_OVF_BIT = 0;
    localparam int ST_MATCH_A_BIT = 1;
    localparam int ST_MATCH_B_BIT = 2;
    localparam int ST_W = 3;
    localparam logic [1:0] OM_OFF = 2'h0;
    localparam logic [1:0] OM_TOGGLE = 2'h1;
    localparam logic [1:0] OM_CLEAR = 2'h2;
    localparam logic [1:0] OM_SET = 2'h3;
    typedef enum logic [2:0] {
        T8W_NORMAL = 3'h0,
        T8W_PHASE_FF = 3'h1,
        T8W_CLR_MATCH = 3'h2,
        T8W_FAST_FF = 3'h3,
        T8W_RSV4 = 3'h4,
        T8W_PHASE_CMP = 3'h5,
        T8W_RSV6 = 3'h6,
        T8W_FAST_CMP = 3'h7
    } t8w_mode_t;
endpackage

// ==== core/t8w_chan.sv ====
// One compare channel: buffered compare value, match detection and waveform flop.
// Assumes the counter, direction and TOP come from the timer core of the same clock.
`timescale 1ns/1ps
module t8w_chan
    import t8w_pkg::*;
#(
    parameter bit PWM_TOGGLE = 1'b0
)
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // Timer state
    input wire logic tick_in,
    input t8w_mode_t mode_in,
    input wire logic wave_mode_high_in,
    input wire logic [7:0] count_in,
    input wire logic [7:0] top_in,
    input wire logic up_in,
    input wire logic block_in,
    input wire logic [1:0] out_mode_in,
    // Compare value write
    input wire logic wr_in,
    input wire logic [7:0] wdata_in,
    // Results
    output logic [7:0] buf_out,
    output logic [7:0] compare_out,
    output logic match_out,
    output logic wave_out,
    output logic connected_out
);
    logic [7:0] buf_q;
    logic [7:0] buf_d;
    logic [7:0] cmp_q;
    logic [7:0] cmp_d;
    logic out_q;
    logic out_d;
    logic match_q;
    logic match_d;
    logic is_fast;
    logic is_phase;
    logic is_pwm;
    logic hit;
    logic at_top;
    logic ignore;

    always_comb
    begin
        is_fast = (mode_in == T8W_FAST_FF) || (mode_in == T8W_FAST_CMP);
        is_phase = (mode_in == T8W_PHASE_FF) || (mode_in == T8W_PHASE_CMP);
        is_pwm = is_fast || is_phase;
        at_top = tick_in && (count_in == top_in);
        buf_d = wr_in ? wdata_in : buf_q;
        // Double buffering keeps a PWM period glitch free at the cost of one period of lag.
        if (!is_pwm)
            cmp_d = buf_d;
        else if (at_top)
            cmp_d = buf_q;
        else
            cmp_d = cmp_q;
        hit = tick_in && !block_in && (count_in == cmp_q);
        match_d = hit;
        ignore = out_mode_in[1] && (cmp_q == top_in);
        out_d = out_q;
        if (!is_pwm)
        begin
            if (hit)
            begin
                unique case (out_mode_in)
                    OM_OFF: out_d = out_q;
                    OM_TOGGLE: out_d = ~out_q;
                    OM_CLEAR: out_d = 1'b0;
                    OM_SET: out_d = 1'b1;
                endcase
            end
        end
        else if (out_mode_in == OM_TOGGLE)
        begin
            if (hit && PWM_TOGGLE && wave_mode_high_in)
                out_d = ~out_q;
        end
        else if (out_mode_in[1] && is_fast)
        begin
            if (at_top)
                out_d = ~out_mode_in[0];
            else if (hit && !ignore)
                out_d = out_mode_in[0];
        end
        else if (out_mode_in[1])
        begin
            if (ignore)
            begin
                if (at_top)
                    out_d = ~out_mode_in[0];
            end
            else if (hit)
                out_d = up_in ? out_mode_in[0] : ~out_mode_in[0];
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            buf_q <= RST_REG;
            cmp_q <= RST_REG;
            out_q <= 1'b0;
            match_q <= 1'b0;
        end
        else
        begin
            buf_q <= buf_d;
            cmp_q <= cmp_d;
            out_q <= out_d;
            match_q <= match_d;
        end
    end

    assign buf_out = buf_q;
    assign compare_out = cmp_q;
    assign match_out = match_q;
    assign wave_out = out_q;
    assign connected_out = (out_mode_in != OM_OFF) &&
        !(is_pwm && out_mode_in == OM_TOGGLE && !(PWM_TOGGLE && wave_mode_high_in));
endmodule // t8w_chan

// ==== tb/t8w_top_assertions.sv ====
// Checker for the timer waveform block, bound to its top module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module t8w_checker
    import t8w_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic sys_rst_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // Timer and pins
    input wire logic timer_tick_enable_in,
    input wire logic chan_a_wave_out,
    input wire logic chan_a_wave_oe_out,
    input wire logic chan_b_wave_out,
    input wire logic chan_b_wave_oe_out,
    input wire logic irq_out
);
    logic [7:0] ctrl_q, ctrl_d, hi_q, hi_d, mask_q, mask_d, dir_q, dir_d;
    logic wr_ctrl, nonpwm;

    // Shadow copies of the registers that steer the pins and the interrupt, kept from the write strobes.
    always_comb
    begin
        wr_ctrl = reg_wr_in && reg_addr_in == ADDR_CTRL_A;
        ctrl_d = wr_ctrl ? (reg_wdata_in & 8'hf3) : ctrl_q;
        hi_d = (reg_wr_in && reg_addr_in == ADDR_CTRL_X) ? reg_wdata_in : hi_q;
        mask_d = (reg_wr_in && reg_addr_in == ADDR_MASK) ? reg_wdata_in : mask_q;
        dir_d = (reg_wr_in && reg_addr_in == ADDR_PIN_DIR) ? reg_wdata_in : dir_q;
        nonpwm = !hi_q[CX_WAVE_HIGH_BIT] && !ctrl_q[0];
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            ctrl_q <= 8'h00;
            hi_q <= 8'h00;
            mask_q <= 8'h00;
            dir_q <= 8'h00;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            hi_q <= hi_d;
            mask_q <= mask_d;
            dir_q <= dir_d;
        end
    end

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
        else $error("read data not zero outside a read");
    a_ctrl_readback: assert property ($past(reg_rd_in && reg_addr_in == ADDR_CTRL_A)
        |-> reg_rdata_out == $past(ctrl_q))
        else $error("control read differs or reserved bits set");
    a_unmapped_zero: assert property ($past(reg_rd_in && reg_addr_in > ADDR_PIN_DIR)
        |-> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    a_irq_masked: assert property (irq_out |-> (mask_q | $past(mask_q)) != 8'h00)
        else $error("interrupt raised with empty mask");
    a_oe_a_cause: assert property (chan_a_wave_oe_out
        |-> $past(ctrl_q[7:6] != 2'h0 && dir_q[0]))
        else $error("pin a driven without mode or direction");
    a_oe_b_cause: assert property (chan_b_wave_oe_out
        |-> $past(ctrl_q[5:4] != 2'h0 && dir_q[1]))
        else $error("pin b driven without mode or direction");
    a_oe_a_drive: assert property ($past(ctrl_q[7:6] != 2'h0 && dir_q[0] && nonpwm)
        |-> chan_a_wave_oe_out)
        else $error("pin a not driven in non pwm mode");
    a_wave_a_hold: assert property (!$past(timer_tick_enable_in) && !$past(reg_wr_in)
        && !$past(sys_rst_in) |-> $stable(chan_a_wave_out))
        else $error("wave a moved without tick");
    a_wave_b_hold: assert property (!$past(timer_tick_enable_in) && !$past(reg_wr_in)
        && !$past(sys_rst_in) |-> $stable(chan_b_wave_out))
        else $error("wave b moved without tick");
endmodule // t8w_checker

bind t8w_top t8w_checker t8w_checker_i (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .timer_tick_enable_in(timer_tick_enable_in),
    .chan_a_wave_out(chan_a_wave_out),
    .chan_a_wave_oe_out(chan_a_wave_oe_out),
    .chan_b_wave_out(chan_b_wave_out),
    .chan_b_wave_oe_out(chan_b_wave_oe_out),
    .irq_out(irq_out)
);

// ==== tb/t8w_load_model.sv ====
// Board load on the two waveform pins, each with a pull-up.
// Assumes the pin enables are high while the block drives the pin.
`timescale 1ns/1ps
module t8w_load_model
(
    // Block side
    input wire logic chan_a_wave_in,
    input wire logic chan_a_wave_oe_in,
    input wire logic chan_b_wave_in,
    input wire logic chan_b_wave_oe_in,
    // Resolved pin levels
    output logic a_pin_out,
    output logic b_pin_out
);
    // A released pin rises through its pull-up instead of keeping the last driven level.
    assign a_pin_out = chan_a_wave_oe_in ? chan_a_wave_in : 1'b1;
    assign b_pin_out = chan_b_wave_oe_in ? chan_b_wave_in : 1'b1;
endmodule // t8w_load_model

// ==== tb/t8w_top_tb.sv ====
// Self-checking bench for the timer waveform block and its pin load.
// Assumes the register port answers reads in the next cycle only.
`timescale 1ns/1ps
module t8w_top_tb
    import t8w_pkg::*;
;
    typedef struct {logic [7:0] ctrl, hi, ca, cb; int ha, hb, win;} t8w_row_t;
    logic core_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic timer_tick_enable_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic chan_a_wave_out, chan_a_wave_oe_out, chan_b_wave_out, chan_b_wave_oe_out, irq_out;
    logic a_pin, b_pin, prev;
    int fail_count = 0;
    int comparisons = 0;
    int ha, hb, n;
    // Steady-state high counts per window, from the pin after its pull-up.
    t8w_row_t rows [7] = '{
        '{8'hb3, 8'h00, 8'h40, 8'hc0, 65, 63, 256},
        '{8'hb3, 8'h00, 8'hff, 8'hc0, 256, 63, 256},
        '{8'h53, 8'h00, 8'h40, 8'hc0, 256, 256, 256},
        '{8'hb1, 8'h00, 8'h40, 8'hc0, 128, 126, 510},
        '{8'hb1, 8'h00, 8'hff, 8'hc0, 510, 126, 510},
        '{8'h63, 8'h08, 8'h3f, 8'h10, 256, 136, 512},
        '{8'ha1, 8'h08, 8'h40, 8'h20, 512, 256, 512}};

    always #25 core_clk_in = ~core_clk_in;

    t8w_top t8w_top_i (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .timer_tick_enable_in(timer_tick_enable_in), .chan_a_wave_out(chan_a_wave_out),
        .chan_a_wave_oe_out(chan_a_wave_oe_out), .chan_b_wave_out(chan_b_wave_out),
        .chan_b_wave_oe_out(chan_b_wave_oe_out), .irq_out(irq_out));
    t8w_load_model t8w_load_model_i (.chan_a_wave_in(chan_a_wave_out),
        .chan_a_wave_oe_in(chan_a_wave_oe_out), .chan_b_wave_in(chan_b_wave_out),
        .chan_b_wave_oe_in(chan_b_wave_oe_out), .a_pin_out(a_pin), .b_pin_out(b_pin));

    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Each access leaves one idle edge so a strobe is never raised and lowered at once.
    task automatic wr(logic [7:0] a, logic [7:0] d);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge core_clk_in);
        reg_wr_in <= 1'b0;
        @(posedge core_clk_in);
    endtask

    task automatic rd(logic [7:0] a, logic [7:0] exp, string name);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge core_clk_in);
        reg_rd_in <= 1'b0;
        #1;
        check(name, {8'h00, reg_rdata_out}, {8'h00, exp});
        @(posedge core_clk_in);
    endtask

    task automatic ticks(int k);
        timer_tick_enable_in <= 1'b1;
        repeat (k) @(posedge core_clk_in);
        timer_tick_enable_in <= 1'b0;
        @(posedge core_clk_in);
        #1;
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge core_clk_in);
        sys_rst_in <= 1'b0;
        @(posedge core_clk_in);
        for (int i = 0; i < 9; i++)
            rd(ADDR_CTRL_A + 8'(i), 8'h00, "reset value");
        wr(ADDR_CTRL_A, 8'hff);
        rd(ADDR_CTRL_A, 8'hf3, "control a");
        wr(8'h30, 8'h55);
        rd(8'h30, 8'h00, "unmapped");
        $display("Test registers done");
        wr(ADDR_CTRL_A, 8'h00);
        wr(ADDR_COUNT, 8'h00);
        repeat (20) @(posedge core_clk_in);
        rd(ADDR_COUNT, 8'h00, "count without tick");
        ticks(3);
        rd(ADDR_COUNT, 8'h03, "count after ticks");
        $display("Test tick enable done");
        wr(ADDR_PIN_DIR, 8'h03);
        wr(ADDR_MASK, 8'h02);
        wr(ADDR_CMP_A, 8'h04);
        wr(ADDR_CMP_B, 8'h02);
        wr(ADDR_CTRL_A, 8'h42);
        timer_tick_enable_in <= 1'b1;
        // Take the starting level after the edge, once the new pin enable has landed.
        #1;
        prev = a_pin;
        n = 0;
        repeat (52)
        begin
            @(posedge core_clk_in);
            #1;
            n += int'(a_pin != prev);
            prev = a_pin;
        end
        timer_tick_enable_in <= 1'b0;
        // From count 3 with TOP 4, a match falls on ticks 2, 7, ... 52.
        check("toggles", 16'(n), 16'h000b);
        check("pin a enable", {15'h0, chan_a_wave_oe_out}, 16'h1);
        check("pin b released", {15'h0, b_pin}, 16'h1);
        check("irq", {15'h0, irq_out}, 16'h1);
        rd(ADDR_STATUS, 8'h06, "status");
        wr(ADDR_MASK, 8'h00);
        #1;
        check("irq masked", {15'h0, irq_out}, 16'h0);
        wr(ADDR_STATUS, 8'h06);
        rd(ADDR_STATUS, 8'h00, "status cleared");
        for (int i = 3; i >= 2; i--)
        begin
            wr(ADDR_CTRL_A, {2'(i), 2'(i), 4'h2});
            ticks(10);
            check("set clear a", {15'h0, a_pin}, 16'(i % 2));
            check("set clear b", {15'h0, b_pin}, 16'(i % 2));
        end
        $display("Test clear on match done");
        foreach (rows[i])
        begin
            wr(ADDR_CTRL_A, 8'h00);
            wr(ADDR_CTRL_X, rows[i].hi);
            wr(ADDR_CMP_A, rows[i].ca);
            wr(ADDR_CMP_B, rows[i].cb);
            wr(ADDR_COUNT, 8'h00);
            wr(ADDR_CTRL_A, rows[i].ctrl);
            wr(ADDR_STATUS, 8'h07);
            timer_tick_enable_in <= 1'b1;
            repeat (600) @(posedge core_clk_in);
            ha = 0;
            hb = 0;
            repeat (rows[i].win)
            begin
                @(posedge core_clk_in);
                #1;
                ha += int'(a_pin);
                hb += int'(b_pin);
            end
            timer_tick_enable_in <= 1'b0;
            check("pin a high", 16'(ha), 16'(rows[i].ha));
            check("pin b high", 16'(hb), 16'(rows[i].hb));
            rd(ADDR_STATUS, 8'h07, "pwm status");
            $display("Test pwm row %0d done", i);
        end
        wr(ADDR_CTRL_A, 8'h00);
        wr(ADDR_CTRL_X, 8'h08);
        wr(ADDR_COUNT, 8'h10);
        ticks(5);
        rd(ADDR_COUNT, 8'h10, "reserved mode count");
        wr(ADDR_CTRL_X, 8'h00);
        wr(ADDR_COUNT, 8'hfe);
        wr(ADDR_STATUS, 8'h07);
        ticks(3);
        rd(ADDR_COUNT, 8'h01, "normal wrap");
        rd(ADDR_STATUS, 8'h01, "normal overflow");
        $display("Test reserved and normal modes done");
        print_verdict();
    end
endmodule // t8w_top_tb
